//--- acm_defs.svh
// Constants for the conversion mode controller: counts, reset values, periods.
// Assumes the system clock is the only clock and runs at the period given here.
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH
// ****************************************
// Timing
// ****************************************
`define ACM_CLK_PS       25000
`define ACM_T_POR_US     50
`define ACM_POR_CYC      ((`ACM_T_POR_US * 1000000 + `ACM_CLK_PS - 1) / `ACM_CLK_PS)
`define ACM_LAT_NORM     210
`define ACM_LAT_TURBO    114
`define ACM_DIV_NORM     16
`define ACM_DIV_TURBO    8
`define ACM_DUTY_IDLE    3
`define ACM_RDY_GAP      2
`define ACM_TEMP_W       14
// ****************************************
// Conversion periods in modulator ticks, one per rate code
// ****************************************
`define ACM_PER_0        16'h3200
`define ACM_PER_1        16'h1639
`define ACM_PER_2        16'h0B1C
`define ACM_PER_3        16'h05B7
`define ACM_PER_4        16'h0308
`define ACM_PER_5        16'h01AB
`define ACM_PER_6        16'h0100
`define ACM_PER_7        16'h0100
// ****************************************
// Configuration reset values
// ****************************************
`define ACM_RST_CM       1'b0
`define ACM_RST_RATE     3'h0
`define ACM_RST_TS       1'b0
`endif

//--- acm_pkg.sv
// Types shared by the conversion mode controller.
// Assumes acm_defs.svh is on the include path.
package acm_pkg;
    // Operating modes; power-down is a command, not a mode code
    typedef enum logic [1:0] {
        ACM_NORMAL = 2'b00,
        ACM_DUTY   = 2'b01,
        ACM_TURBO  = 2'b10,
        ACM_RSVD   = 2'b11
    } acm_opmode_t;
    // Configuration bits written by the command port
    typedef struct packed {
        logic        conversion_mode_bit;
        logic [2:0]  rate_select;
        acm_opmode_t op_mode;
        logic        temp_sensor_select;
    } acm_cfg_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_POR   = 3'b000,
        ST_LAT   = 3'b001,
        ST_CONV  = 3'b010,
        ST_IDLE  = 3'b011,
        ST_DWAIT = 3'b100,
        ST_DOWN  = 3'b101
    } acm_state_t;
endpackage : acm_pkg

//--- acm_ctrl.sv
// Conversion sequencer: power-up, single-shot/continuous, operating modes.
// Assumes commands arrive as one-cycle pulses decoded by the serial port,
// and that the analog front end presents sample and temperature words.
// Operation
// - Temperature is 14 bits, left-aligned, 1/32 degree
// - Negative temperature is two's complement
// - Power-on reset sequence lasts about 50 us
// - Power-up reset restores configuration defaults
// - After power-up, one single-shot conversion, then sleep
// - Conversion end drives ready output low
// - One bit selects single-shot or continuous
// - Single-shot converts once per trigger, then sleeps
// - Single-shot sleep stops oscillator and analog, keeps excitation
// - Single-shot: config write aborts and restarts conversion
// - Continuous: load result, start next at once
// - Start latency 210 clocks, 114 in turbo
// - Continuous: config write restarts running conversion
// - Normal, duty, turbo, power-down; normal by default
// - Normal modulator clock is system clock over 16
// - Three-bit rate field picks the data rate
// - Rates scale with the system clock
// - Duty mode: one conversion then three idle periods
// - Duty mode gives quarter of normal rates
// - Turbo modulator clock is system clock over 8
// - Power-down waits for running conversion to finish
// - Config write while down wakes for one conversion
// - Ready output returns high on serial clock rise
`timescale 1ns/1ps
`include "acm_defs.svh"
`default_nettype none
module acm_ctrl
    import acm_pkg::*;
#(
    parameter int POR_CYC = `ACM_POR_CYC     // Power-up reset length in clocks
)(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // Decoded command pulses
    input  wire logic                   start_cmd,
    input  wire logic                   sleep_cmd,
    input  wire logic                   reset_cmd,
    input  wire logic                   cfg_write,
    input  wire acm_cfg_t               cfg_in,
    input  wire logic                   sclk_rise,
    // Analog front end results
    input  wire logic [15:0]            sample_data,
    input  wire logic [`ACM_TEMP_W-1:0] temp_data,
    // Status and control outputs
    output var  acm_cfg_t               cfg_out,
    output logic [15:0]                 result,
    output logic                        result_ready_n,
    output logic                        osc_en,
    output logic                        analog_en,
    output logic                        excite_en,
    output logic                        mod_tick,
    output logic                        busy
);
    // ****************************************
    // State
    // ****************************************
    acm_state_t  state_r, state_nxt;      // Sequencer state
    acm_cfg_t    cfg_r, cfg_nxt;          // Configuration bits
    logic [15:0] cnt_r, cnt_nxt;          // Shared cycle or tick counter
    logic [3:0]  div_r, div_nxt;          // Modulator divider
    logic        single_r, single_nxt;    // Current run is one conversion
    logic        pend_r, pend_nxt;        // Power-down waiting for end
    logic [15:0] res_r, res_nxt;          // Output buffer
    logic        rdy_n_r, rdy_n_nxt;      // Ready, active low
    logic        osc_r, osc_nxt;
    logic        ana_r, ana_nxt;
    logic        exc_r, exc_nxt;
    logic        tick_r, tick_nxt;
    logic        busy_r, busy_nxt;
    // Combinational helpers
    logic        tick;                    // Modulator clock enable
    logic        trig;                    // Trigger from command or write
    logic        done;                    // Conversion finishes this cycle
    logic [15:0] per;                     // Period of the chosen rate
    logic [3:0]  div_lim;
    logic [15:0] lat_lim;

    // Period lookup in modulator ticks
    always_comb
    begin
        unique case (cfg_r.rate_select)
            3'h0: per = `ACM_PER_0;
            3'h1: per = `ACM_PER_1;
            3'h2: per = `ACM_PER_2;
            3'h3: per = `ACM_PER_3;
            3'h4: per = `ACM_PER_4;
            3'h5: per = `ACM_PER_5;
            3'h6: per = `ACM_PER_6;
            3'h7: per = `ACM_PER_7;
        endcase
    end

    // ****************************************
    // Modulator divider and helper terms
    // ****************************************
    // Turbo halves the divide ratio, so every tick-based period speeds up alike
    always_comb
    begin
        div_lim = (cfg_r.op_mode == ACM_TURBO) ? 4'(`ACM_DIV_TURBO - 1)
                                                : 4'(`ACM_DIV_NORM - 1);
        lat_lim = (cfg_r.op_mode == ACM_TURBO) ? 16'(`ACM_LAT_TURBO - 1)
                                                : 16'(`ACM_LAT_NORM - 1);
        tick    = (div_r >= div_lim);
        trig    = (start_cmd || cfg_write) && (state_r != ST_POR) && !reset_cmd;
        done    = (state_r == ST_CONV) && tick && (cnt_r == per - 16'h0001) && !trig && !reset_cmd;
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    // One process for all control state; trigger beats end of conversion
    always_comb
    begin
        state_nxt  = state_r;
        cfg_nxt    = cfg_r;
        cnt_nxt    = cnt_r;
        div_nxt    = tick ? 4'h0 : div_r + 4'h1;
        single_nxt = single_r;
        pend_nxt   = pend_r;
        res_nxt    = res_r;
        rdy_n_nxt  = rdy_n_r;
        // Serial clock rise releases ready
        if (sclk_rise)
            rdy_n_nxt = 1'b1;
        if (cfg_write)
            cfg_nxt = cfg_in;
        unique case (state_r)
            // Power-up reset wait, then one single-shot conversion
            ST_POR:
            begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(POR_CYC - 1))
                begin
                    state_nxt  = ST_LAT;
                    cnt_nxt    = 16'h0000;
                    single_nxt = 1'b1;
                end
            end
            // Start latency in system clocks
            ST_LAT:
            begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == lat_lim)
                begin
                    state_nxt = ST_CONV;
                    cnt_nxt   = 16'h0000;
                    div_nxt   = 4'h0;
                end
            end
            // Conversion counts modulator ticks
            ST_CONV:
            begin
                if (tick)
                    cnt_nxt = cnt_r + 16'h0001;
                // Brief high before a new unread result in continuous runs
                if (tick && !single_r && !rdy_n_r && (cnt_r == per - 16'(`ACM_RDY_GAP + 1)))
                    rdy_n_nxt = 1'b1;
                if (done)
                begin
                    res_nxt   = cfg_r.temp_sensor_select ? {temp_data, 2'b00} : sample_data;
                    rdy_n_nxt = 1'b0;
                    cnt_nxt   = 16'h0000;
                    if (pend_r)
                    begin
                        state_nxt = ST_DOWN;
                        pend_nxt  = 1'b0;
                    end
                    else if (single_r)
                        state_nxt = ST_IDLE;
                    else if (cfg_r.op_mode == ACM_DUTY)
                        state_nxt = ST_DWAIT;
                    else
                        state_nxt = ST_CONV;
                end
            end
            // Duty-cycle rest for three periods, analog off
            ST_DWAIT:
            begin
                if (tick)
                    cnt_nxt = cnt_r + 16'h0001;
                if (tick && (cnt_r == 16'(`ACM_DUTY_IDLE) * per - 16'h0001))
                begin
                    state_nxt = ST_CONV;
                    cnt_nxt   = 16'h0000;
                end
            end
            // Low power between single conversions, or powered down
            ST_IDLE, ST_DOWN:
                cnt_nxt = 16'h0000;
            default:
                state_nxt = ST_POR;
        endcase
        // Power-down finishes a running conversion first
        if (sleep_cmd && !trig)
        begin
            if (done || (state_nxt inside {ST_IDLE, ST_DWAIT}))
                state_nxt = ST_DOWN;
            else if (state_nxt != ST_DOWN)
                pend_nxt = 1'b1;
        end
        // Trigger or write: abort and restart from the latency phase
        if (trig)
        begin
            state_nxt  = ST_LAT;
            cnt_nxt    = 16'h0000;
            pend_nxt   = 1'b0;
            single_nxt = !cfg_nxt.conversion_mode_bit || (state_r == ST_DOWN && cfg_write);
        end
        // Soft reset behaves like power-up, except that the result buffer and ready keep their values
        if (reset_cmd)
        begin
            state_nxt = ST_POR;
            cnt_nxt   = 16'h0000;
            pend_nxt  = 1'b0;
            cfg_nxt   = '{`ACM_RST_CM, `ACM_RST_RATE, ACM_NORMAL, `ACM_RST_TS};
        end
        // Power gating follows the next state
        osc_nxt  = !(state_nxt inside {ST_IDLE, ST_DWAIT, ST_DOWN});
        ana_nxt  = osc_nxt;
        exc_nxt  = (state_nxt != ST_DOWN);
        tick_nxt = tick && (state_r == ST_CONV);
        busy_nxt = (state_nxt inside {ST_POR, ST_LAT, ST_CONV});
    end

    // ****************************************
    // Registers
    // ****************************************
    // Everything powers up in the reset sequence with default configuration
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r  <= ST_POR;
            cfg_r    <= '{`ACM_RST_CM, `ACM_RST_RATE, ACM_NORMAL, `ACM_RST_TS};
            cnt_r    <= 16'h0000;
            div_r    <= 4'h0;
            single_r <= 1'b1;
            pend_r   <= 1'b0;
            res_r    <= 16'h0000;
            rdy_n_r  <= 1'b1;
            osc_r    <= 1'b1;
            ana_r    <= 1'b1;
            exc_r    <= 1'b1;
            tick_r   <= 1'b0;
            busy_r   <= 1'b1;
        end
        else
        begin
            state_r  <= state_nxt;
            cfg_r    <= cfg_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= div_nxt;
            single_r <= single_nxt;
            pend_r   <= pend_nxt;
            res_r    <= res_nxt;
            rdy_n_r  <= rdy_n_nxt;
            osc_r    <= osc_nxt;
            ana_r    <= ana_nxt;
            exc_r    <= exc_nxt;
            tick_r   <= tick_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // Outputs straight from flops
    assign cfg_out        = cfg_r;
    assign result         = res_r;
    assign result_ready_n = rdy_n_r;
    assign osc_en         = osc_r;
    assign analog_en      = ana_r;
    assign excite_en      = exc_r;
    assign mod_tick       = tick_r;
    assign busy           = busy_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_por_exit;
        (state_r == ST_POR) && (cnt_r == 16'(POR_CYC - 1)) && !reset_cmd |=> (state_r == ST_LAT) && single_r;
    endproperty
    a_por_exit: assert property (p_por_exit) else $error("reset wait did not end on count");
    property p_rdy_fall;
        done |=> !result_ready_n && busy == (state_r == ST_CONV);
    endproperty
    a_rdy_fall: assert property (p_rdy_fall) else $error("ready not low after conversion");
    property p_rdy_rise;
        sclk_rise && !done |=> result_ready_n;
    endproperty
    a_rdy_rise: assert property (p_rdy_rise) else $error("ready not released by serial clock");
    property p_single_idle;
        done && single_r && !pend_r && !sleep_cmd |=> (state_r == ST_IDLE) ##1 !osc_en;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single run did not sleep");
    property p_cont_next;
        done && !single_r && !pend_r && !sleep_cmd && (cfg_r.op_mode != ACM_DUTY)
            |=> (state_r == ST_CONV) && (cnt_r == 16'h0000) && (result == $past(res_nxt));
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous run did not restart");
    property p_restart;
        trig |=> (state_r == ST_LAT) && (cnt_r == 16'h0000);
    endproperty
    a_restart: assert property (p_restart) else $error("write or trigger did not restart");
    property p_lat_turbo;
        (state_r == ST_LAT) && (cfg_r.op_mode == ACM_TURBO) && (cnt_r == 16'(`ACM_LAT_TURBO - 1))
            && !trig && !reset_cmd |=> (state_r == ST_CONV);
    endproperty
    a_lat_turbo: assert property (p_lat_turbo) else $error("turbo start latency wrong");
    property p_temp;
        done && cfg_r.temp_sensor_select |=> result == {$past(temp_data), 2'b00};
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not left aligned");
    property p_sleep_gate;
        (state_r == ST_IDLE) |-> !osc_en && !analog_en && excite_en;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("low power gating wrong");
    property p_wake;
        (state_r == ST_DOWN) && cfg_write && !reset_cmd |=> (state_r == ST_LAT) && single_r;
    endproperty
    a_wake: assert property (p_wake) else $error("write did not wake for one conversion");

    c_por_done:  cover property ((state_r == ST_POR) ##1 (state_r == ST_LAT));
    c_duty:      cover property (done && (cfg_r.op_mode == ACM_DUTY) && !single_r);
    c_down_wake: cover property ((state_r == ST_DOWN) ##1 (state_r == ST_LAT));
    c_abort:     cover property ((state_r == ST_CONV) && trig);
endmodule : acm_ctrl
`default_nettype wire

//--- acm_host.sv
// Host model: issues decoded command pulses to the conversion sequencer.
// Assumes one clock; every command is a one-cycle pulse launched after an edge.
`timescale 1ns/1ps
`include "acm_defs.svh"
`default_nettype none
module acm_host
    import acm_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Command pulses
    output logic      start_cmd,
    output logic      sleep_cmd,
    output logic      reset_cmd,
    output logic      cfg_write,
    output var acm_cfg_t cfg_in,
    output logic      sclk_rise
);
    // ****************************************
    // Idle bus
    // ****************************************
    // No command in flight at time zero
    initial
    begin
        start_cmd = 1'h0;
        sleep_cmd = 1'h0;
        reset_cmd = 1'h0;
        cfg_write = 1'h0;
        cfg_in    = '0;
        sclk_rise = 1'h0;
    end
    // ****************************************
    // Command tasks
    // ****************************************
    // One pulse: 0 start, 1 sleep, 2 reset, 3 serial clock rise
    task automatic pulse(input logic [1:0] k);
        @(posedge ref_clk);
        case (k)
            2'h0: start_cmd <= 1'h1;
            2'h1: sleep_cmd <= 1'h1;
            2'h2: reset_cmd <= 1'h1;
            default: sclk_rise <= 1'h1;
        endcase
        @(posedge ref_clk);
        {start_cmd, sleep_cmd, reset_cmd, sclk_rise} <= 4'h0;
    endtask : pulse
    // Whole word write; data lines show garbage once released
    task automatic write_cfg(input acm_cfg_t c);
        @(posedge ref_clk);
        cfg_in    <= c;
        cfg_write <= 1'h1;
        @(posedge ref_clk);
        cfg_write <= 1'h0;
        cfg_in    <= ~c;
    endtask : write_cfg
    // Mode bit first, trigger right behind it
    task automatic enter_cont(input acm_cfg_t c);
        write_cfg(c);
        pulse(2'h0);
    endtask : enter_cont
endmodule : acm_host
`default_nettype wire

//--- adc_conversion_mode_control_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes acm_defs.svh on the include path; host model drives all commands.
`timescale 1ns/1ps
`include "acm_defs.svh"
`default_nettype none
module adc_conversion_mode_control_tb
    import acm_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    localparam int TOL = 6;          // Slack for pulse launch edges
    logic        ref_clk, rstn;
    logic        start_cmd, sleep_cmd, reset_cmd, cfg_write, sclk_rise;
    acm_cfg_t    cfg_in, cfg_out, dflt;
    logic [15:0] sample_data, result;
    logic [13:0] temp_data;
    logic        result_ready_n, osc_en, analog_en, excite_en, mod_tick, busy;
    int          n_errors, cmp_count;
    // Short POR so the run stays brief
    acm_ctrl #(.POR_CYC(20)) dut (.ref_clk(ref_clk), .rstn(rstn), .start_cmd(start_cmd),
        .sleep_cmd(sleep_cmd), .reset_cmd(reset_cmd), .cfg_write(cfg_write), .cfg_in(cfg_in),
        .sclk_rise(sclk_rise), .sample_data(sample_data), .temp_data(temp_data),
        .cfg_out(cfg_out), .result(result), .result_ready_n(result_ready_n), .osc_en(osc_en),
        .analog_en(analog_en), .excite_en(excite_en), .mod_tick(mod_tick), .busy(busy));
    acm_host host (.ref_clk(ref_clk), .start_cmd(start_cmd), .sleep_cmd(sleep_cmd),
        .reset_cmd(reset_cmd), .cfg_write(cfg_write), .cfg_in(cfg_in), .sclk_rise(sclk_rise));
    // Clock at 25 ns
    initial
    begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ****************************************
    // Helpers
    // ****************************************
    // Value compare
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Cycle count compare with slack
    task automatic chk_n(input string what, input int exp, input int got);
        cmp_count++;
        if (got < exp - TOL || got > exp + TOL)
        begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n
    // Conversion length in clocks for rate codes 5 to 7
    function automatic int conv_cyc(input logic [2:0] r, input logic turbo);
        int p;
        case (r)
            3'h5: p = `ACM_PER_5;
            3'h6: p = `ACM_PER_6;
            default: p = `ACM_PER_7;
        endcase
        return p * (turbo ? `ACM_DIV_TURBO : `ACM_DIV_NORM);
    endfunction : conv_cyc
    // Clear ready, then count clocks to the next falling edge of it
    task automatic wait_fall(output int n, output int ticks);
        logic seen_hi;
        seen_hi = 1'h0;
        ticks = 0;
        host.pulse(2'h3);
        n = 2;
        while (!(seen_hi && result_ready_n === 1'h0) && n < 40000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (mod_tick === 1'h1)
                ticks++;
            if (result_ready_n === 1'h1)
                seen_hi = 1'h1;
        end
    endtask : wait_fall
    // ****************************************
    // Scenarios
    // ****************************************
    // Defaults, then the one automatic conversion
    task automatic t_powerup;
        int n, t;
        chk("cfg_dflt", {9'h0, dflt}, {9'h0, cfg_out});
        chk("op_dflt", {14'h0, ACM_NORMAL}, {14'h0, cfg_out.op_mode});
        host.write_cfg('{1'h0, 3'h6, ACM_NORMAL, 1'h0});
        wait_fall(n, t);
        chk_n("por_first", 20 + `ACM_LAT_NORM + conv_cyc(3'h6, 1'h0), n + 2);
        chk("first_res", sample_data, result);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("sleep_osc", 16'h0000, {13'h0, osc_en, analog_en, busy});
        chk("sleep_exc", 16'h0001, {15'h0, excite_en});
    endtask : t_powerup
    // Each write is a trigger; rate code sets length
    task automatic t_rates;
        int n, t;
        for (int r = 5; r < 8; r++)
        begin
            host.write_cfg('{1'h0, r[2:0], ACM_NORMAL, 1'h0});
            wait_fall(n, t);
            chk_n("rate_len", `ACM_LAT_NORM + conv_cyc(r[2:0], 1'h0), n);
        end
    endtask : t_rates
    // Start command, tick count, ready released by serial clock
    task automatic t_start;
        int n, t;
        // New front-end word so the buffer really reloads
        @(posedge ref_clk);
        sample_data <= 16'h5A3C;
        host.pulse(2'h0);
        wait_fall(n, t);
        chk_n("start_len", `ACM_LAT_NORM + conv_cyc(3'h7, 1'h0), n);
        chk_n("ticks", `ACM_PER_7, t);
        chk("start_res", sample_data, result);
        host.pulse(2'h3);
        @(posedge ref_clk);
        #1;
        chk("rdy_clear", 16'h0001, {15'h0, result_ready_n});
    endtask : t_start
    // Write mid-conversion restarts it; temperature format
    task automatic t_restart;
        int n, t;
        host.pulse(2'h0);
        repeat (1000) @(posedge ref_clk);
        host.write_cfg('{1'h0, 3'h6, ACM_NORMAL, 1'h1});
        wait_fall(n, t);
        chk_n("abort_len", `ACM_LAT_NORM + conv_cyc(3'h6, 1'h0), n);
        chk("temp_res", {temp_data, 2'h0}, result);
        chk("temp_sign", 16'h0001, {15'h0, result[15]});
        // Positive reading keeps the top bit clear
        @(posedge ref_clk);
        temp_data <= 14'h0640;
        host.pulse(2'h0);
        wait_fall(n, t);
        chk("temp_pos", 16'h1900, result);
        chk("temp_plus", 16'h0000, {15'h0, result[15]});
    endtask : t_restart
    // Turbo continuous run, restart, sleep and wake
    task automatic t_cont;
        int n, t;
        acm_cfg_t c;
        c = '{1'h1, 3'h6, ACM_TURBO, 1'h0};
        host.enter_cont(c);
        wait_fall(n, t);
        chk_n("turbo_lat", `ACM_LAT_TURBO + conv_cyc(3'h6, 1'h1), n);
        wait_fall(n, t);
        chk_n("cont_next", conv_cyc(3'h6, 1'h1), n);
        repeat (500) @(posedge ref_clk);
        host.write_cfg(c);
        wait_fall(n, t);
        chk_n("cont_rst", `ACM_LAT_TURBO + conv_cyc(3'h6, 1'h1), n);
        host.pulse(2'h1);
        wait_fall(n, t);
        chk_n("sleep_end", conv_cyc(3'h6, 1'h1) - 2, n);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("down_en", 16'h0000, {13'h0, osc_en, analog_en, excite_en});
        host.write_cfg(c);
        wait_fall(n, t);
        chk_n("wake_len", `ACM_LAT_TURBO + conv_cyc(3'h6, 1'h1), n);
        host.pulse(2'h3);
        repeat (3000) @(posedge ref_clk);
        #1;
        chk("wake_once", 16'h0001, {14'h0, busy, result_ready_n});
    endtask : t_cont
    // Duty cycle: one conversion, three periods of rest; then soft reset
    task automatic t_duty;
        int n, t;
        host.enter_cont('{1'h1, 3'h6, ACM_DUTY, 1'h0});
        wait_fall(n, t);
        chk_n("duty_lat", `ACM_LAT_NORM + conv_cyc(3'h6, 1'h0), n);
        repeat (100) @(posedge ref_clk);
        #1;
        chk("duty_rest", 16'h0000, {15'h0, osc_en});
        wait_fall(n, t);
        chk_n("duty_per", (1 + `ACM_DUTY_IDLE) * conv_cyc(3'h6, 1'h0) - 100, n);
        host.pulse(2'h2);
        #1;
        chk("soft_rst", {9'h0, dflt}, {9'h0, cfg_out});
        // Hard reset during the soft reset wait: buffer cleared, reset wait starts over
        @(posedge ref_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        #1;
        chk("hard_rst", 16'h0007, {13'h0, busy, result_ready_n, osc_en});
        chk("hard_res", 16'h0000, result);
    endtask : t_duty
    // ****************************************
    // Verdict and sequence
    // ****************************************
    // Single exit point of the run
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Hang guard, well past the expected 69k cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        n_errors    = 0;
        cmp_count   = 0;
        rstn        = 1'h0;
        dflt        = '{`ACM_RST_CM, `ACM_RST_RATE, ACM_NORMAL, `ACM_RST_TS};
        sample_data = 16'hA5C3;
        temp_data   = 14'h3CE0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'h1;
        @(posedge ref_clk);
        #1;
        t_powerup();
        t_rates();
        t_start();
        t_restart();
        t_cont();
        t_duty();
        tally_and_finish();
    end
endmodule : adc_conversion_mode_control_tb
`default_nettype wire
